// ### inc/gpio_port_defines.svh
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define ADDR_PORTA_DATA       8'h00
`define ADDR_PORTA_DIR        8'h01
`define ADDR_PORTB_DATA       8'h02
`define ADDR_PORTB_DIR        8'h03
`define ADDR_EDGE_IRQ_ENABLE  8'h08

// ****************************************************************
// Reset values
// ****************************************************************
`define PORT_DATA_RESET       8'h00
`define PORT_DIR_RESET        8'h00
`define EDGE_IRQ_EN_RESET     8'h00
`define RDATA_IDLE            8'h00

// ****************************************************************
// Field positions and edge polarity
// ****************************************************************
// Bit n of the enable register arms source n+1; sources 1 to 4 sit on
// port A pins 4 to 7 and sources 5 to 8 on port B pins 4 to 7.
`define SRC_PIN_LO            4
`define SRC_PIN_HI            7
// A one marks a rising-edge source, a zero a falling-edge source.
`define EDGE_RISING_MASK      8'h33
// Converter channels with this bit clear select a port B pin.
`define ADC_BANK_BIT          3
`define ADC_ONE_HOT_BASE      8'h01

`endif

// ### inc/gpio_port_pkg.sv
package gpio_port_pkg;

  typedef logic [7:0] port_byte_t;

  typedef struct packed {
    port_byte_t porta_latch;
    port_byte_t porta_dir;
    port_byte_t portb_latch;
    port_byte_t portb_dir;
    port_byte_t edge_irq_enable;
    port_byte_t rd_data;
    port_byte_t analog_sel;
    logic       src_active_prev;
    logic       irq_pending;
    logic       irq_event;
  } port_state_t;

  typedef struct packed {
    port_byte_t meta;
    port_byte_t stable;
  } sync_state_t;

endpackage

// ### inc/pin_drive_if.sv
`timescale 1ns/100ps

interface pin_drive_if;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] alt_oe;
  logic [7:0] alt_out;
  logic [7:0] alt_od;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] is_output;

  modport ctrl (
    output dir,
    output latch,
    output alt_oe,
    output alt_out,
    output alt_od,
    input  pin_out,
    input  pin_oe,
    input  is_output
  );

  modport drv (
    input  dir,
    input  latch,
    input  alt_oe,
    input  alt_out,
    input  alt_od,
    output pin_out,
    output pin_oe,
    output is_output
  );
endinterface

// ### hdl/pin_sync.sv
`timescale 1ns/100ps

module pin_sync
  import gpio_port_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_pin,
  output logic      [7:0] o_level
);

  sync_state_t st_q;
  sync_state_t st_d;

  // Only the second stage is read; the first may be metastable.
  always_comb begin
    st_d        = st_q;
    st_d.meta   = i_pin;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.stable;

endmodule

// ### hdl/pin_driver.sv
`timescale 1ns/100ps

module pin_driver (
  pin_drive_if.drv bus
);

  // A claimed pin ignores direction and latch entirely.
  assign bus.pin_out   = (bus.alt_oe & ~bus.alt_od & bus.alt_out)
                       | (~bus.alt_oe & bus.latch);  // [RULE14] [RULE12]
  // Open drain drives only the low level and floats for a one.
  assign bus.pin_oe    = (bus.alt_oe & (~bus.alt_od | ~bus.alt_out))
                       | (~bus.alt_oe & bus.dir);  // [RULE15] [RULE7]
  assign bus.is_output = bus.alt_oe | bus.dir;  // [RULE15]

endmodule

// ### hdl/gpio_edge_port.sv
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "gpio_port_defines.svh"

// How it works
// RULE1 - Enable register eight bits, read/write, resets zero.
// RULE2 - Enable bit n-1 arms source n.
// RULE3 - Sources 1,2,5,6 fire on rising edges.
// RULE4 - Sources 3,4,7,8 fire on falling edges.
// RULE5 - Only eight fixed pins can raise requests.
// RULE6 - Software disables analog input before port B interrupts.
// RULE7 - Direction bit one means output, zero input.
// RULE8 - Every pin configurable on its own.
// RULE9 - Input pin reads return the pin level.
// RULE10 - Software writes latch before switching to output.
// RULE11 - Armed sources are ORed into one request.
// RULE12 - Output pins drive and read back the latch.
// RULE13 - Output pins never raise interrupts.
// RULE14 - Peripheral claim overrides direction and latch.
// RULE15 - Peripheral drive forces output, push-pull or open-drain.
// RULE16 - Peripheral input pins still read back pin level.
// RULE17 - Shared in/out peripheral pins use direction zero.
// RULE18 - No alternate function on armed input pins.
// RULE19 - Selected converter pin joins the analog rail.
// RULE20 - Keep pins steady during an analog conversion.
// RULE21 - Requests reach the CPU only when unmasked.
// RULE22 - Synchronise pins, compare samples, pulse per edge.
module gpio_edge_port
  import gpio_port_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // Register port.
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Port A pins.
  input  wire logic [7:0] i_porta_pin,
  output logic      [7:0] o_porta_pin,
  output logic      [7:0] o_porta_oe,
  // Port B pins.
  input  wire logic [7:0] i_portb_pin,
  output logic      [7:0] o_portb_pin,
  output logic      [7:0] o_portb_oe,
  // On-chip peripheral claims of port A.
  input  wire logic [7:0] i_porta_alt_oe,
  input  wire logic [7:0] i_porta_alt_out,
  input  wire logic [7:0] i_porta_alt_od,
  output logic      [7:0] o_porta_level,
  // On-chip peripheral claims of port B.
  input  wire logic [7:0] i_portb_alt_oe,
  input  wire logic [7:0] i_portb_alt_out,
  input  wire logic [7:0] i_portb_alt_od,
  output logic      [7:0] o_portb_level,
  // Analog multiplexer control from the converter.
  input  wire logic       i_adc_active,
  input  wire logic [3:0] i_adc_chan,
  output logic      [7:0] o_portb_analog_sel,
  // CPU interrupt handshake.
  input  wire logic       i_irq_mask,
  input  wire logic       i_irq_ack,
  output logic            o_ext_irq,
  output logic            o_ext_irq_event
);

  // ****************************************************************
  // Pin synchronisers and drivers
  // ****************************************************************
  logic [7:0] porta_level;
  logic [7:0] portb_level;

  pin_drive_if porta_if ();
  pin_drive_if portb_if ();

  pin_sync u_porta_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_porta_pin),
    .o_level   (porta_level)
  );  // [RULE22]

  pin_sync u_portb_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_portb_pin),
    .o_level   (portb_level)
  );  // [RULE22]

  pin_driver u_porta_drv (
    .bus (porta_if.drv)
  );

  pin_driver u_portb_drv (
    .bus (portb_if.drv)
  );

  port_state_t st_q;
  port_state_t st_d;

  assign porta_if.dir     = st_q.porta_dir;
  assign porta_if.latch   = st_q.porta_latch;
  assign porta_if.alt_oe  = i_porta_alt_oe;
  assign porta_if.alt_out = i_porta_alt_out;
  assign porta_if.alt_od  = i_porta_alt_od;

  assign portb_if.dir     = st_q.portb_dir;
  assign portb_if.latch   = st_q.portb_latch;
  assign portb_if.alt_oe  = i_portb_alt_oe;
  assign portb_if.alt_out = i_portb_alt_out;
  assign portb_if.alt_od  = i_portb_alt_od;

  // ****************************************************************
  // Readback of the data registers
  // ****************************************************************
  // Each bit chooses on its own, so a port can mix inputs and
  // outputs freely. Peripheral-driven pins with a clear direction bit
  // still return the pin, which is what a peripheral input needs.
  port_byte_t porta_readback;
  port_byte_t portb_readback;

  assign porta_readback = (st_q.porta_dir & st_q.porta_latch)
                        | (~st_q.porta_dir & porta_level);
  // [RULE9] [RULE12] [RULE16] [RULE8]
  assign portb_readback = (st_q.portb_dir & st_q.portb_latch)
                        | (~st_q.portb_dir & portb_level);
  // [RULE9] [RULE12] [RULE16] [RULE8]

  // ****************************************************************
  // External edge sources
  // ****************************************************************
  // Source order follows the enable register: port A pins 4..7 give
  // sources one to four, port B pins 4..7 give five to eight. No other
  // pin is wired in here.
  port_byte_t src_level;
  port_byte_t src_output;
  port_byte_t src_active;
  logic       group_active;
  logic       group_rise;
  logic       porta_pin_four;
  logic       porta_pin_five;
  logic       porta_pin_six;
  logic       porta_pin_seven;
  logic       portb_pin_four;
  logic       portb_pin_five;
  logic       portb_pin_six;
  logic       portb_pin_seven;
  logic       ext_source_one;
  logic       ext_source_two;
  logic       ext_source_three;
  logic       ext_source_four;
  logic       ext_source_five;
  logic       ext_source_six;
  logic       ext_source_seven;
  logic       ext_source_eight;

  // Rising sources sit on pins four and five, falling ones on six and
  // seven, in both ports.
  assign porta_pin_four  = porta_level[`SRC_PIN_LO];  // [RULE3]
  assign porta_pin_five  = porta_level[`SRC_PIN_LO + 1];  // [RULE3]
  assign porta_pin_six   = porta_level[`SRC_PIN_HI - 1];  // [RULE4]
  assign porta_pin_seven = porta_level[`SRC_PIN_HI];  // [RULE4]
  assign portb_pin_four  = portb_level[`SRC_PIN_LO];  // [RULE3]
  assign portb_pin_five  = portb_level[`SRC_PIN_LO + 1];  // [RULE3]
  assign portb_pin_six   = portb_level[`SRC_PIN_HI - 1];  // [RULE4]
  assign portb_pin_seven = portb_level[`SRC_PIN_HI];  // [RULE4]

  assign src_level  = {portb_pin_seven, portb_pin_six,
                       portb_pin_five,  portb_pin_four,
                       porta_pin_seven, porta_pin_six,
                       porta_pin_five,  porta_pin_four};  // [RULE5]
  assign src_output = {portb_if.is_output[`SRC_PIN_HI:`SRC_PIN_LO],
                       porta_if.is_output[`SRC_PIN_HI:`SRC_PIN_LO]};

  // A rising source is active while high, a falling one while low.
  // The group then sees one edge on the OR of all active sources,
  // so one armed pin stuck in its active level hides the others.
  assign src_active = st_q.edge_irq_enable & ~src_output
                    & ~(src_level ^ `EDGE_RISING_MASK);
  // [RULE2] [RULE3] [RULE4] [RULE13]

  assign ext_source_one   = src_active[0];  // [RULE2]
  assign ext_source_two   = src_active[1];  // [RULE2]
  assign ext_source_three = src_active[2];  // [RULE2]
  assign ext_source_four  = src_active[3];  // [RULE2]
  assign ext_source_five  = src_active[4];  // [RULE2]
  assign ext_source_six   = src_active[5];  // [RULE2]
  assign ext_source_seven = src_active[6];  // [RULE2]
  assign ext_source_eight = src_active[7];  // [RULE2]

  // ****************************************************************
  // Group request
  // ****************************************************************
  // All eight sources share one vector, so they meet in a plain OR.
  assign group_active = ext_source_one   | ext_source_two
                      | ext_source_three | ext_source_four
                      | ext_source_five  | ext_source_six
                      | ext_source_seven | ext_source_eight;  // [RULE11]
  assign group_rise   = group_active & ~st_q.src_active_prev;  // [RULE22]

  // ****************************************************************
  // Analog multiplexer
  // ****************************************************************
  // The selection is only decoded here; the digital input path stays
  // live, so software must keep armed port B pins off the rail.
  logic       adc_on_portb;
  port_byte_t analog_sel_next;

  assign adc_on_portb    = i_adc_active & ~i_adc_chan[`ADC_BANK_BIT];
  assign analog_sel_next = adc_on_portb
                         ? port_byte_t'(`ADC_ONE_HOT_BASE << i_adc_chan[2:0])
                         : `RDATA_IDLE;  // [RULE19]

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_d         = st_q;
    st_d.rd_data = `RDATA_IDLE;

    // Writes to the latch land even while the pin is an input, so the
    // level is ready before the direction flips.
    if (i_wr) begin
      case (i_addr)
        `ADDR_PORTA_DATA: begin
          st_d.porta_latch = i_wdata;  // [RULE10]
        end
        `ADDR_PORTA_DIR: begin
          st_d.porta_dir = i_wdata;  // [RULE7]
        end
        `ADDR_PORTB_DATA: begin
          st_d.portb_latch = i_wdata;  // [RULE10]
        end
        `ADDR_PORTB_DIR: begin
          st_d.portb_dir = i_wdata;  // [RULE7]
        end
        `ADDR_EDGE_IRQ_ENABLE: begin
          st_d.edge_irq_enable = i_wdata;  // [RULE1]
        end
        default: begin
        end
      endcase
    end

    // Read data stands for the one cycle after the strobe only.
    if (i_rd) begin
      case (i_addr)
        `ADDR_PORTA_DATA: begin
          st_d.rd_data = porta_readback;
        end
        `ADDR_PORTA_DIR: begin
          st_d.rd_data = st_q.porta_dir;
        end
        `ADDR_PORTB_DATA: begin
          st_d.rd_data = portb_readback;
        end
        `ADDR_PORTB_DIR: begin
          st_d.rd_data = st_q.portb_dir;
        end
        `ADDR_EDGE_IRQ_ENABLE: begin
          st_d.rd_data = st_q.edge_irq_enable;  // [RULE1]
        end
        default: begin
          st_d.rd_data = `RDATA_IDLE;
        end
      endcase
    end

    st_d.src_active_prev = group_active;  // [RULE22]
    st_d.irq_event       = group_rise;  // [RULE22]

    // An edge seen in the acknowledge cycle keeps the request alive.
    // The latch also holds a request taken while the CPU is masked.
    st_d.irq_pending = group_rise
                     | (st_q.irq_pending & ~i_irq_ack);  // [RULE11]

    // The multiplexer only reaches port B for channels zero to seven;
    // higher channels belong to another port.
    st_d.analog_sel = analog_sel_next;  // [RULE19]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q                 <= '0;
      st_q.porta_latch     <= `PORT_DATA_RESET;
      st_q.porta_dir       <= `PORT_DIR_RESET;
      st_q.portb_latch     <= `PORT_DATA_RESET;
      st_q.portb_dir       <= `PORT_DIR_RESET;
      st_q.edge_irq_enable <= `EDGE_IRQ_EN_RESET;  // [RULE1]
      st_q.rd_data         <= `RDATA_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rdata            = st_q.rd_data;
  assign o_porta_pin        = porta_if.pin_out;
  assign o_porta_oe         = porta_if.pin_oe;
  assign o_portb_pin        = portb_if.pin_out;
  assign o_portb_oe         = portb_if.pin_oe;
  assign o_porta_level      = porta_level;  // [RULE16]
  assign o_portb_level      = portb_level;  // [RULE16]
  assign o_portb_analog_sel = st_q.analog_sel;
  assign o_ext_irq_event    = st_q.irq_event;
  // A masked request waits in the latch until the mask clears.
  assign o_ext_irq          = st_q.irq_pending & ~i_irq_mask;  // [RULE21]

endmodule

// ### verification/pin_world.sv
`timescale 1ns/100ps
// ****
// Board-side pin model
// ****
module pin_world (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_pull,
  output logic      [7:0] o_pin
);
  logic [7:0] float_q = 8'h00;
  // A released line with no pull-up flips every cycle, so a stale level
  // can never pass for real data.
  always @(posedge i_clk_sys) float_q <= ~float_q;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
               | (~i_oe & ~i_ext_en & (i_pull | float_q));
endmodule

// ### verification/gpio_port_checker.sv
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
// ****
// Port behaviour checks
// ****
module gpio_port_checker (
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_porta_pin,
  input wire logic [7:0] o_porta_pin,
  input wire logic [7:0] o_porta_oe,
  input wire logic [7:0] i_porta_alt_oe,
  input wire logic [7:0] o_porta_level,
  input wire logic [7:0] i_portb_pin,
  input wire logic [7:0] o_portb_level,
  input wire logic [7:0] o_portb_pin,
  input wire logic [7:0] o_portb_oe,
  input wire logic [7:0] i_portb_alt_oe,
  input wire logic [7:0] i_portb_alt_out,
  input wire logic [7:0] i_portb_alt_od,
  input wire logic       i_adc_active,
  input wire logic [3:0] i_adc_chan,
  input wire logic [7:0] o_portb_analog_sel,
  input wire logic       i_irq_mask,
  input wire logic       i_irq_ack,
  input wire logic       o_ext_irq,
  input wire logic       o_ext_irq_event
);
  logic [1:0] up_q;
  logic [7:0] pp;
  logic [7:0] od;
  assign pp = i_portb_alt_oe & ~i_portb_alt_od;
  assign od = i_portb_alt_oe & i_portb_alt_od;
  // The synchroniser holds reset values for a while after release.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  AST_DIR_OE: assert property (i_wr && i_addr == `ADDR_PORTA_DIR |=>
    (o_porta_oe & ~i_porta_alt_oe) == ($past(i_wdata) & ~i_porta_alt_oe))
    else $error("direction write not on enables");
  AST_LATCH: assert property (i_wr && i_addr == `ADDR_PORTA_DATA |=>
    ((o_porta_pin ^ $past(i_wdata)) & o_porta_oe & ~i_porta_alt_oe) == 0)
    else $error("output pin differs from latch");
  AST_PP: assert property ((o_portb_oe & pp) == pp
    && (o_portb_pin & pp) == (i_portb_alt_out & pp))
    else $error("push-pull claim not driven");
  AST_OD: assert property ((o_portb_oe & od) == (~i_portb_alt_out & od)
    && (o_portb_pin & o_portb_oe & od) == 8'h00)
    else $error("open-drain claim wrong");
  AST_SYNC: assert property (up_q == 2'h3
    |-> o_porta_level == $past(i_porta_pin, 2))
    else $error("pin level not two cycles late");
  AST_SYNC_B: assert property (up_q == 2'h3
    |-> o_portb_level == $past(i_portb_pin, 2))
    else $error("port B level not two cycles late");
  AST_MASK: assert property (i_irq_mask |-> !o_ext_irq)
    else $error("request while masked");
  AST_EVT: assert property (o_ext_irq_event && !i_irq_mask |-> o_ext_irq)
    else $error("edge without request");
  AST_ACK: assert property (i_irq_ack ##1 !o_ext_irq_event |-> !o_ext_irq)
    else $error("request survives ack");
  AST_ADC: assert property (i_adc_active && !i_adc_chan[3] |=>
    o_portb_analog_sel == (8'h01 << $past(i_adc_chan)))
    else $error("analog select wrong");
endmodule

bind gpio_edge_port gpio_port_checker chk_u (.*);

// ### verification/tb_top.sv
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module tb_top;
  import gpio_port_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  port_byte_t  addr = 8'h00;
  port_byte_t  wdata = 8'h00;
  port_byte_t  va = 8'h3c;
  port_byte_t  vb = 8'h3c;
  port_byte_t  a_oe = 8'h00, a_out = 8'h00, a_od = 8'h00;
  port_byte_t  b_oe = 8'h00, b_out = 8'h00, b_od = 8'h00;
  port_byte_t  rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, sel, q, v;
  logic        mask = 1'b0, ack = 1'b0, irq, evt;
  // The converter stays idle while port B pins are armed.
  logic        adc_on = 1'b0;
  logic [3:0]  chan = 4'h0;
  int          err_total = 0, checks = 0, n;
  logic [23:0] rows [8] = '{24'h01ffff, 24'h03ffff, 24'h005a5a,
    24'h02c3c3, 24'h08a5a5, 24'h053c00, 24'h010000, 24'h00003c};

  always #10 clk = ~clk;

  gpio_edge_port dut_u (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_porta_pin(pa_in), .o_porta_pin(pa_out), .o_porta_oe(pa_oe),
    .i_portb_pin(pb_in), .o_portb_pin(pb_out), .o_portb_oe(pb_oe),
    .i_porta_alt_oe(a_oe), .i_porta_alt_out(a_out), .i_porta_alt_od(a_od),
    .o_porta_level(), .i_portb_alt_oe(b_oe), .i_portb_alt_out(b_out),
    .i_portb_alt_od(b_od), .o_portb_level(), .i_adc_active(adc_on),
    .i_adc_chan(chan), .o_portb_analog_sel(sel), .i_irq_mask(mask),
    .i_irq_ack(ack), .o_ext_irq(irq), .o_ext_irq_event(evt));
  pin_world pa_u (.i_clk_sys(clk), .i_oe(pa_oe), .i_out(pa_out),
    .i_ext_en(8'hff), .i_ext_val(va), .i_pull(8'hff), .o_pin(pa_in));
  pin_world pb_u (.i_clk_sys(clk), .i_oe(pb_oe), .i_out(pb_out),
    .i_ext_en(8'hff), .i_ext_val(vb), .i_pull(8'h00), .o_pin(pb_in));

  // ****
  // Shared tasks
  // ****
  task automatic chk(input port_byte_t got, input port_byte_t exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic r, input port_byte_t a, input port_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= r;
    wr <= ~r;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic pins(input port_byte_t a, input port_byte_t b);
    @(posedge clk);
    va <= a;
    vb <= b;
  endtask
  task automatic pulse_ack();
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask
  task automatic watch(input int k, input int want);
    n = 0;
    repeat (k) begin
      @(posedge clk);
      #1 n += (evt === 1'b1);
    end
    chk(n[7:0], want[7:0]);
  endtask
  task automatic stop_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200us;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      acc(1'b0, rows[i][23:16], rows[i][15:8]);
      acc(1'b1, rows[i][23:16], 8'h00);
      chk(q, rows[i][7:0]);
    end
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    acc(1'b1, `ADDR_EDGE_IRQ_ENABLE, 8'h00);
    chk(q, 8'h00);
    for (int s = 0; s < 8; s++) begin
      v = (s % 4 < 2) ? 8'h00 : 8'hff;
      pins(v, v);
      acc(1'b0, `ADDR_EDGE_IRQ_ENABLE, 8'h01 << s);
      pulse_ack();
      watch(4, 0);
      if (s < 4) pins(v ^ (8'h10 << s), v);
      else pins(v, v ^ (8'h10 << (s - 4)));
      watch(5, 1);
      chk({7'h00, irq}, 8'h01);
      pins(v, v);
      watch(5, 0);
      acc(1'b0, `ADDR_EDGE_IRQ_ENABLE, 8'h00);
      pulse_ack();
    end
    pins(8'hc0, 8'hc0);
    acc(1'b0, `ADDR_EDGE_IRQ_ENABLE, 8'hff);
    pulse_ack();
    pins(8'hcf, 8'hcf);
    pins(8'hc0, 8'hc0);
    watch(6, 0);
    @(posedge clk);
    mask <= 1'b1;
    pins(8'h80, 8'hc0);
    watch(5, 1);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    mask <= 1'b0;
    #1 chk({7'h00, irq}, 8'h01);
    pins(8'h00, 8'hc0);
    watch(6, 0);
    acc(1'b0, `ADDR_EDGE_IRQ_ENABLE, 8'h00);
    pins(8'hc0, 8'hc0);
    pulse_ack();
    acc(1'b0, `ADDR_EDGE_IRQ_ENABLE, 8'h01);
    acc(1'b0, `ADDR_PORTA_DATA, 8'h00);
    acc(1'b0, `ADDR_PORTA_DIR, 8'h10);
    acc(1'b0, `ADDR_PORTA_DATA, 8'h10);
    watch(6, 0);
    chk(pa_in & 8'h10, 8'h10);
    acc(1'b0, `ADDR_EDGE_IRQ_ENABLE, 8'h00);
    pins(8'hc0, 8'hf4);
    @(posedge clk);
    {a_oe, a_out, a_od} <= {8'h01, 8'h01, 8'h00};
    {b_oe, b_out, b_od} <= {8'h0f, 8'h05, 8'h0c};
    repeat (3) @(posedge clk);
    acc(1'b1, `ADDR_PORTB_DATA, 8'h00);
    chk(q, 8'hf5);
    chk(pb_oe, 8'h0b);
    chk(pb_out & pb_oe, 8'h01);
    chk(pa_oe, 8'h11);
    chk(pa_out & 8'h01, 8'h01);
    @(posedge clk);
    adc_on <= 1'b1;
    chan <= 4'h5;
    @(posedge clk);
    #1 chk(sel, 8'h20);
    @(posedge clk);
    chan <= 4'h9;
    @(posedge clk);
    #1 chk(sel, 8'h00);
    stop_test();
  end
endmodule
